// ==== src/lpr_map.svh ====
// Bit positions, codes and defaults of the proprietary packet receiver.
`ifndef LPR_MAP_SVH
`define LPR_MAP_SVH
// ************************************************************
// Option byte bit positions
// ************************************************************
`define LPR_OPT_SYNTH_OFF 0
`define LPR_OPT_RESUME_GOOD 1
`define LPR_OPT_RESUME_BAD 2
`define LPR_OPT_CRC_CHECK 3
`define LPR_OPT_LEN_FIRST 4
`define LPR_OPT_ADDR_FILTER 5
`define LPR_OPT_CRC_SYNC 4
`define LPR_OPT_CRC_HDR 5
`define LPR_OPT_END_BEHAV 6
`define LPR_OPT_MISMATCH 7
// ************************************************************
// Header configuration fields
// ************************************************************
`define LPR_HDR_BITS_LSB 0
`define LPR_HDR_BITS_MSB 5
`define LPR_HDR_POS_LSB 6
`define LPR_HDR_POS_MSB 10
`define LPR_HDR_LEN_LSB 11
`define LPR_HDR_LEN_MSB 15
// ************************************************************
// Stop trigger classes, result status codes, address, sync and CRC constants
// ************************************************************
`define LPR_TRIG_NEVER 8'h00
`define LPR_TRIG_TIME 8'h01
`define LPR_TRIG_PIN 8'h02
`define LPR_STAT_GOOD_END 8'h01
`define LPR_STAT_BAD_END 8'h02
`define LPR_STAT_TRIG_END 8'h03
`define LPR_STAT_ABORT 8'h04
`define LPR_ADDR_ALL_ONES 8'hFF
`define LPR_ADDR_ZERO 8'h00
`define LPR_SYNC_BITS 6'h20
`define LPR_CRC_POLY 16'h1021
`define LPR_CRC_INIT 16'hFFFF
`define LPR_CRC_BITS 5'h10
`endif

// ==== src/lpr_pkg.sv ====
// Types shared by the proprietary packet receiver design files.
package lpr_pkg;
  // Parameter block of the basic receive command.
  typedef struct packed {
    logic [7:0] packet_options;
    logic [7:0] receive_options;
    logic [31:0] sync_pattern;
    logic [7:0] length_limit;
    logic [7:0] match_addr_a;
    logic [7:0] match_addr_b;
    logic [7:0] stop_trigger_class;
    logic [31:0] stop_time;
    logic [31:0] rx_queue_ptr;
    logic [31:0] result_ptr;
  } lpr_basic_s;
  // Parameter block of the advanced receive command.
  typedef struct packed {
    logic [7:0] packet_options;
    logic [7:0] receive_options;
    logic [31:0] primary_sync_pattern;
    logic [31:0] alternate_sync_pattern;
    logic [15:0] length_limit;
    logic [15:0] header_config;
    logic [7:0] stop_trigger_class;
    logic [31:0] stop_time;
    logic [31:0] rx_queue_ptr;
    logic [31:0] result_ptr;
  } lpr_adv_s;
  // Result structure written when a command ends.
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] n_good;
    logic [7:0] n_bad;
    logic [7:0] n_ignored;
  } lpr_result_s;
  // One byte write into the receive queue.
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data;
  } lpr_qwr_s;
  // Receiver states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_SYNC, ST_HDR, ST_BODY, ST_CRC, ST_DONE
  } lpr_state_e;
endpackage

// ==== src/lpr_crc.sv ====
// Serial CRC engine with a one-cycle whole-word preload.
`timescale 1ns/1ns
`include "lpr_map.svh"
module lpr_crc #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control.
  input wire logic init,
  input wire logic word_en,
  input wire logic [31:0] word_in,
  input wire logic bit_en,
  input wire logic bit_in,
  // Running value.
  output logic [W-1:0] crc_reg
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [W-1:0] crc;
  } lpr_crc_s;
  lpr_crc_s st_reg; // Registered state.
  lpr_crc_s st_next; // Next state.

  // One bit through the divider, most significant bit first.
  function automatic logic [W-1:0] crc_step(input logic [W-1:0] c, input logic b);
    logic fb;
    fb = c[W-1] ^ b;
    crc_step = {c[W-2:0], 1'b0} ^ (fb ? W'(`LPR_CRC_POLY) : W'(0));
  endfunction

  // Preload folds a whole sync word in at once, so it can be covered after the match.
  always_comb begin
    logic [W-1:0] c;
    c = st_reg.crc;
    if (init) begin
      c = W'(`LPR_CRC_INIT);
    end
    if (word_en) begin
      for (int i = 31; i >= 0; i--) begin
        c = crc_step(c, word_in[i]);
      end
    end
    if (bit_en) begin
      c = crc_step(c, bit_in);
    end
    st_next.crc = c;
  end

  // Register the state.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg.crc <= W'(`LPR_CRC_INIT);
    end else begin
      st_reg <= st_next;
    end
  end

  assign crc_reg = st_reg.crc;
endmodule

// ==== src/lpr_addr_filter.sv ====
// Address byte comparison against the two match values.
`timescale 1ns/1ns
`include "lpr_map.svh"
module lpr_addr_filter (
  // Received and configured addresses.
  input wire logic [7:0] addr,
  input wire logic [7:0] match_addr_a,
  input wire logic [7:0] match_addr_b,
  // Verdict.
  output logic hit
);
  // Equal match values leave a single accepted address unless both are all ones, which also accepts zero.
  always_comb begin
    hit = (addr == match_addr_a) || (addr == match_addr_b);
    if (match_addr_b == `LPR_ADDR_ALL_ONES && addr == `LPR_ADDR_ZERO) begin
      hit = 1'b1;
    end
  end
endmodule

// ==== src/lpr_receiver.sv ====
// Receive-side packet engine: sync search, header, length, address filter, CRC and result.
// Function
// - Synth off after command when bit set.
// - Good packet: end, or resume sync search.
// - CRC error packet: end, or resume search.
// - Check CRC only when enabled.
// - Basic variable length comes from first byte.
// - Filter accepts either of two match addresses.
// - Second match all ones also accepts zero.
// - End trigger finishes or aborts current packet.
// - Mismatch restarts search or marks packet ignored.
// - Basic length exact or bound; zero unlimited.
// - Search for 32-bit sync pattern first.
// - Advanced also searches nonzero alternate pattern.
// - Advanced CRC may cover sync word.
// - Advanced CRC may cover header.
// - Advanced header width zero to thirty-two.
// - Length field offset zero to thirty-one.
// - Advanced 16-bit length limit; zero unlimited.
// - Stop by trigger class and stop time.
// - Packets to queue, results to result pointer.
// - Multibyte little endian, aligned.
// - Host parameters read, never modified.
// - Header length field zero to sixteen bits.
`timescale 1ns/1ns
`include "lpr_map.svh"
module lpr_receiver (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command start and parameter blocks.
  input wire logic cmd_start,
  input wire logic cmd_advanced,
  input wire lpr_pkg::lpr_basic_s basic_cfg,
  input wire lpr_pkg::lpr_adv_s adv_cfg,
  // Demodulated bit stream.
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  // External stop trigger pin.
  input wire logic end_trig_pin,
  // Status.
  output logic busy,
  output logic synth_off,
  // Result.
  output logic cmd_done,
  output lpr_pkg::lpr_result_s result,
  output logic [31:0] result_addr,
  // Receive queue writes.
  output logic q_wr,
  output lpr_pkg::lpr_qwr_s q_wr_data
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    lpr_pkg::lpr_state_e st; // Sequencer state.
    logic adv; // Advanced command in progress.
    logic [31:0] sr; // Sync search window.
    logic [5:0] sync_cnt; // Bits in the window, saturating.
    logic [31:0] hdr; // Header shift register.
    logic [5:0] hdr_cnt; // Header bits taken.
    logic [2:0] bit_cnt; // Bit within the byte.
    logic [7:0] byte_sh; // Byte assembly.
    logic [15:0] byte_idx; // Bytes of this packet so far.
    logic [15:0] pkt_len; // Expected payload length.
    logic len_known; // Length bound is in force.
    logic [4:0] crc_cnt; // CRC bits taken.
    logic ignored; // Packet marked ignored.
    logic end_pend; // Stop requested, finishing packet.
    logic [31:0] timer; // Cycles since command start.
    logic [15:0] q_off; // Next queue byte offset.
    logic [15:0] pkt_q0; // Queue offset at packet start.
    logic q_wr; // Queue write pulse.
    lpr_pkg::lpr_qwr_s q_data; // Queue write address and byte.
    logic done; // Command end pulse.
    lpr_pkg::lpr_result_s res; // Result counters and status.
    logic fs_off; // Synthesizer power-down request.
    logic [2:0] trig_s; // Pin synchroniser chain.
    logic trig_lvl; // Accepted pin level.
  } lpr_rx_s;
  lpr_rx_s st_reg; // Registered state.
  lpr_rx_s st_next; // Next state.

  // ************************************************************
  // Parameter selection
  // ************************************************************
  logic [7:0] p_opt; // Option byte of the active command.
  logic [7:0] p_class; // Stop trigger class.
  logic [31:0] p_time; // Stop time.
  logic [31:0] p_queue; // Queue base.
  logic [31:0] p_result; // Result structure base.
  logic [15:0] p_limit; // Length limit, widened.
  logic [5:0] p_hdr_bits; // Header width.
  logic [4:0] p_len_pos; // Length field offset.
  logic [4:0] p_len_bits; // Length field width.
  logic crc_init; // CRC restart.
  logic crc_word; // CRC sync word preload.
  logic crc_bit; // CRC bit feed.
  logic [31:0] crc_word_val; // Sync word that matched.
  logic [15:0] crc_val; // Running CRC.
  logic addr_hit; // Address filter verdict.

  // Parameters are only ever read; the host owns the blocks.
  always_comb begin
    p_opt = st_reg.adv ? adv_cfg.packet_options : basic_cfg.packet_options;
    p_class = st_reg.adv ? adv_cfg.stop_trigger_class : basic_cfg.stop_trigger_class;
    p_time = st_reg.adv ? adv_cfg.stop_time : basic_cfg.stop_time;
    p_queue = st_reg.adv ? adv_cfg.rx_queue_ptr : basic_cfg.rx_queue_ptr;
    p_result = st_reg.adv ? adv_cfg.result_ptr : basic_cfg.result_ptr;
    p_limit = st_reg.adv ? adv_cfg.length_limit : {8'h00, basic_cfg.length_limit};
    p_hdr_bits = adv_cfg.header_config[`LPR_HDR_BITS_MSB:`LPR_HDR_BITS_LSB];
    p_len_pos = adv_cfg.header_config[`LPR_HDR_POS_MSB:`LPR_HDR_POS_LSB];
    p_len_bits = adv_cfg.header_config[`LPR_HDR_LEN_MSB:`LPR_HDR_LEN_LSB];
  end

  // Mask of the low n bits; widths past sixteen saturate.
  function automatic logic [15:0] low_mask(input logic [4:0] n);
    logic [16:0] m;
    m = (17'h00001 << n) - 17'h00001;
    low_mask = (n > 5'h10) ? 16'hFFFF : m[15:0];
  endfunction

  // ************************************************************
  // Helpers
  // ************************************************************
  lpr_crc #(
    .W(16)
  ) u_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .init(crc_init),
    .word_en(crc_word),
    .word_in(crc_word_val),
    .bit_en(crc_bit),
    .bit_in(rx_bit),
    .crc_reg(crc_val)
  );

  lpr_addr_filter u_filter (
    .addr({st_reg.byte_sh[6:0], rx_bit}),
    .match_addr_a(basic_cfg.match_addr_a),
    .match_addr_b(basic_cfg.match_addr_b),
    .hit(addr_hit)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  // One pass decides the next state; packet end and stop are merged at the bottom.
  always_comb begin
    logic [31:0] win;
    logic [7:0] b;
    logic [15:0] len;
    logic [15:0] total;
    logic fire;
    logic pkt_end;
    logic pkt_bad;
    logic resume;
    logic sync_a;
    logic sync_b;
    win = '0;
    b = '0;
    len = '0;
    total = '0;
    pkt_end = 1'b0;
    pkt_bad = 1'b0;
    resume = 1'b0;
    fire = 1'b0;
    sync_a = 1'b0;
    sync_b = 1'b0;
    st_next = st_reg;
    st_next.q_wr = 1'b0;
    st_next.done = 1'b0;
    crc_init = 1'b0;
    crc_word = 1'b0;
    crc_bit = 1'b0;
    crc_word_val = '0;
    // Three-stage pin chain; a change counts when the last two agree.
    st_next.trig_s = {st_reg.trig_s[1:0], end_trig_pin};
    if (st_reg.trig_s[1] == st_reg.trig_s[2]) begin
      st_next.trig_lvl = st_reg.trig_s[2];
    end
    st_next.timer = st_reg.timer + 32'h00000001;
    case (p_class)
      `LPR_TRIG_TIME: fire = (st_reg.timer >= p_time);
      `LPR_TRIG_PIN: fire = st_next.trig_lvl && !st_reg.trig_lvl;
      default: fire = 1'b0;
    endcase
    // Sync candidates in the window after this bit.
    win = {st_reg.sr[30:0], rx_bit};
    sync_a = (win == (st_reg.adv ? adv_cfg.primary_sync_pattern : basic_cfg.sync_pattern));
    sync_b = st_reg.adv && (adv_cfg.alternate_sync_pattern != 32'h00000000)
      && (win == adv_cfg.alternate_sync_pattern);
    case (st_reg.st)
      lpr_pkg::ST_IDLE, lpr_pkg::ST_DONE: begin
        // A new command restarts counters and clears the power-down request.
        if (cmd_start) begin
          st_next = '0;
          st_next.trig_s = {st_reg.trig_s[1:0], end_trig_pin};
          st_next.trig_lvl = st_reg.trig_lvl;
          st_next.adv = cmd_advanced;
          st_next.st = lpr_pkg::ST_SYNC;
        end
      end
      lpr_pkg::ST_SYNC: begin
        // Before sync the stop always ends the command at once.
        if (fire) begin
          st_next.st = lpr_pkg::ST_DONE;
          st_next.done = 1'b1;
          st_next.res.status = `LPR_STAT_TRIG_END;
          st_next.fs_off = p_opt[`LPR_OPT_SYNTH_OFF];
        end else if (rx_bit_valid) begin
          st_next.sr = win;
          if (st_reg.sync_cnt != `LPR_SYNC_BITS) begin
            st_next.sync_cnt = st_reg.sync_cnt + 6'h01;
          end
          // A full window is needed so stale bits never fake a match.
          if ((st_next.sync_cnt == `LPR_SYNC_BITS) && (sync_a || sync_b)) begin
            crc_init = 1'b1;
            crc_word_val = win;
            crc_word = st_reg.adv && p_opt[`LPR_OPT_CRC_SYNC];
            st_next.sync_cnt = '0;
            st_next.hdr = '0;
            st_next.hdr_cnt = '0;
            st_next.bit_cnt = '0;
            st_next.byte_idx = '0;
            st_next.crc_cnt = '0;
            st_next.ignored = 1'b0;
            st_next.pkt_q0 = st_reg.q_off;
            st_next.pkt_len = p_limit;
            st_next.len_known = (p_limit != 16'h0000);
            st_next.st = (st_reg.adv && p_hdr_bits != 6'h00) ? lpr_pkg::ST_HDR : lpr_pkg::ST_BODY;
          end
        end
      end
      lpr_pkg::ST_HDR: begin
        if (rx_bit_valid) begin
          crc_bit = p_opt[`LPR_OPT_CRC_CHECK] && p_opt[`LPR_OPT_CRC_HDR];
          st_next.hdr = {st_reg.hdr[30:0], rx_bit};
          st_next.hdr_cnt = st_reg.hdr_cnt + 6'h01;
          if (st_next.hdr_cnt == p_hdr_bits) begin
            st_next.st = lpr_pkg::ST_BODY;
            if (p_len_bits != 5'h00) begin
              len = 16'(st_next.hdr >> p_len_pos) & low_mask(p_len_bits);
              st_next.pkt_len = len;
              st_next.len_known = 1'b1;
              // A field beyond the limit cannot be trusted.
              if (p_limit != 16'h0000 && len > p_limit) begin
                pkt_end = 1'b1;
                pkt_bad = 1'b1;
              end else if (len == 16'h0000) begin
                st_next.st = p_opt[`LPR_OPT_CRC_CHECK] ? lpr_pkg::ST_CRC : lpr_pkg::ST_BODY;
                pkt_end = !p_opt[`LPR_OPT_CRC_CHECK];
              end
            end
          end
        end
      end
      lpr_pkg::ST_BODY: begin
        if (rx_bit_valid) begin
          crc_bit = p_opt[`LPR_OPT_CRC_CHECK];
          st_next.byte_sh = {st_reg.byte_sh[6:0], rx_bit};
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
          if (st_reg.bit_cnt == 3'h7) begin
            b = st_next.byte_sh;
            st_next.byte_idx = st_reg.byte_idx + 16'h0001;
            // Bytes land one after another from a word-aligned queue base.
            st_next.q_wr = 1'b1;
            st_next.q_data.addr = {p_queue[31:2], 2'b00} + {16'h0000, st_reg.q_off};
            st_next.q_data.data = b;
            st_next.q_off = st_reg.q_off + 16'h0001;
            total = st_reg.pkt_len;
            if (!st_reg.adv && p_opt[`LPR_OPT_LEN_FIRST]) begin
              total = st_reg.pkt_len + 16'h0001;
              if (st_reg.byte_idx == 16'h0000) begin
                st_next.pkt_len = {8'h00, b};
                st_next.len_known = 1'b1;
                total = {8'h00, b} + 16'h0001;
                if (st_reg.len_known && {8'h00, b} > st_reg.pkt_len) begin
                  pkt_end = 1'b1;
                  pkt_bad = 1'b1;
                end
              end
            end
            // The address sits after the length byte, or first when fixed.
            if (!st_reg.adv && p_opt[`LPR_OPT_ADDR_FILTER] && !addr_hit
                && st_reg.byte_idx == (p_opt[`LPR_OPT_LEN_FIRST] ? 16'h0001 : 16'h0000)) begin
              if (p_opt[`LPR_OPT_MISMATCH]) begin
                st_next.ignored = 1'b1;
              end else begin
                // Drop the partial packet from the queue and search again.
                st_next.q_off = st_reg.pkt_q0;
                st_next.q_wr = 1'b0;
                st_next.st = lpr_pkg::ST_SYNC;
              end
            end
            if (!pkt_end && st_next.st == lpr_pkg::ST_BODY && st_next.len_known
                && st_next.byte_idx == total) begin
              st_next.st = p_opt[`LPR_OPT_CRC_CHECK] ? lpr_pkg::ST_CRC : lpr_pkg::ST_BODY;
              pkt_end = !p_opt[`LPR_OPT_CRC_CHECK];
            end
          end
        end
      end
      lpr_pkg::ST_CRC: begin
        // Feeding the check bits through leaves a zero remainder when intact.
        if (rx_bit_valid) begin
          crc_bit = 1'b1;
          st_next.crc_cnt = st_reg.crc_cnt + 5'h01;
          if (st_next.crc_cnt == `LPR_CRC_BITS) begin
            pkt_end = 1'b1;
          end
        end
      end
      default: begin
        st_next.st = lpr_pkg::ST_IDLE;
      end
    endcase
    // The remainder is only valid one cycle after the last bit is folded in.
    if (st_reg.st == lpr_pkg::ST_CRC && st_reg.crc_cnt == `LPR_CRC_BITS) begin
      pkt_end = 1'b1;
      pkt_bad = (crc_val != 16'h0000);
    end else if (st_next.st == lpr_pkg::ST_CRC && st_next.crc_cnt == `LPR_CRC_BITS) begin
      pkt_end = 1'b0;
    end
    // A stop after sync either waits for the packet or cuts it short.
    if (fire && (st_reg.st == lpr_pkg::ST_HDR || st_reg.st == lpr_pkg::ST_BODY
        || st_reg.st == lpr_pkg::ST_CRC)) begin
      if (p_opt[`LPR_OPT_END_BEHAV]) begin
        pkt_end = 1'b0;
        st_next.q_wr = 1'b0;
        st_next.st = lpr_pkg::ST_DONE;
        st_next.done = 1'b1;
        st_next.res.status = `LPR_STAT_ABORT;
        st_next.fs_off = p_opt[`LPR_OPT_SYNTH_OFF];
      end else begin
        st_next.end_pend = 1'b1;
      end
    end
    // Packet bookkeeping and the choice between ending and searching again.
    if (pkt_end) begin
      if (st_next.ignored) begin
        st_next.res.n_ignored = st_reg.res.n_ignored + 8'h01;
      end else if (pkt_bad) begin
        st_next.res.n_bad = st_reg.res.n_bad + 8'h01;
      end else begin
        st_next.res.n_good = st_reg.res.n_good + 8'h01;
      end
      resume = pkt_bad ? p_opt[`LPR_OPT_RESUME_BAD] : p_opt[`LPR_OPT_RESUME_GOOD];
      if (resume && !st_next.end_pend) begin
        st_next.st = lpr_pkg::ST_SYNC;
        st_next.sync_cnt = '0;
      end else begin
        st_next.st = lpr_pkg::ST_DONE;
        st_next.done = 1'b1;
        st_next.res.status = st_next.end_pend ? `LPR_STAT_TRIG_END
          : (pkt_bad ? `LPR_STAT_BAD_END : `LPR_STAT_GOOD_END);
        st_next.fs_off = p_opt[`LPR_OPT_SYNTH_OFF];
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // All state moves together on each clock edge.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign busy = (st_reg.st != lpr_pkg::ST_IDLE) && (st_reg.st != lpr_pkg::ST_DONE);
  assign synth_off = st_reg.fs_off;
  assign cmd_done = st_reg.done;
  assign result = st_reg.res;
  assign result_addr = p_result;
  assign q_wr = st_reg.q_wr;
  assign q_wr_data = st_reg.q_data;
endmodule

// ==== verif/lpr_receiver_checker.sv ====
// Port-level assertions for the packet receiver.
`timescale 1ns/1ns
module lpr_receiver_checker (
  // Clock, reset and inputs.
  input wire logic ref_clk, rst_n, cmd_start, cmd_advanced, rx_bit_valid, rx_bit, end_trig_pin,
  input wire lpr_pkg::lpr_basic_s basic_cfg,
  input wire lpr_pkg::lpr_adv_s adv_cfg,
  // Outputs.
  input wire logic busy, synth_off, cmd_done, q_wr,
  input wire lpr_pkg::lpr_result_s result,
  input wire logic [31:0] result_addr,
  input wire lpr_pkg::lpr_qwr_s q_wr_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Command type of the running command; basic checks skip advanced runs.
  logic adv_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) adv_reg <= 1'b0;
    else if (cmd_start && !busy) adv_reg <= cmd_advanced;
  end
  sequence s_take;
    cmd_start && !busy && !cmd_done;
  endsequence
  sequence s_run;
    busy && !cmd_done;
  endsequence
  start_busy_a: assert property (s_take |=> s_run) else $error("start not taken");
  done_pulse_a: assert property (cmd_done |=> !cmd_done) else $error("done too long");
  done_idle_a: assert property (cmd_done |-> !busy) else $error("busy at done");
  synth_set_a: assert property (cmd_done && !adv_reg |-> synth_off == basic_cfg.packet_options[0])
    else $error("synth off wrong");
  synth_clr_a: assert property (s_take |=> !synth_off) else $error("synth off kept");
  result_ptr_a: assert property (busy && !adv_reg |-> result_addr == basic_cfg.result_ptr)
    else $error("result address wrong");
  byte_gap_a: assert property (q_wr |=> !q_wr [*7]) else $error("queue writes too close");
  queue_base_a: assert property (q_wr && !adv_reg |-> q_wr_data.addr[31:2] >= basic_cfg.rx_queue_ptr[31:2])
    else $error("queue address low");
  result_hold_a: assert property (cmd_done && !cmd_start |=> $stable(result)) else $error("result moved");
  write_busy_a: assert property (q_wr |-> $past(busy)) else $error("write outside command");
endmodule
bind lpr_receiver lpr_receiver_checker chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_start(cmd_start),
  .cmd_advanced(cmd_advanced), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .end_trig_pin(end_trig_pin),
  .basic_cfg(basic_cfg), .adv_cfg(adv_cfg), .busy(busy), .synth_off(synth_off), .cmd_done(cmd_done),
  .q_wr(q_wr), .result(result), .result_addr(result_addr), .q_wr_data(q_wr_data));

// ==== verif/lpr_host_model.sv ====
// Host RAM model that collects receive queue bytes.
`timescale 1ns/1ns
module lpr_host_model (
  // Clock.
  input wire logic ref_clk,
  // Queue writes.
  input wire logic q_wr,
  input wire lpr_pkg::lpr_qwr_s q_wr_data
);
  // Sparse RAM; a byte never written reads as unknown, so a lost write shows.
  logic [7:0] ram [logic [31:0]];
  always @(posedge ref_clk) begin
    if (q_wr === 1'b1) ram[q_wr_data.addr] = q_wr_data.data;
  end
endmodule

// ==== verif/lpr_receiver_tb_top.sv ====
// Self-checking bench of the packet receiver.
`timescale 1ns/1ns
module lpr_receiver_tb_top;
  logic ref_clk, rst_n, cmd_start, cmd_advanced, rx_bit_valid, rx_bit, end_trig_pin;
  logic busy, synth_off, cmd_done, q_wr, done_seen;
  logic [31:0] result_addr, seed, base;
  logic [15:0] crc;
  logic [7:0] pk[$];
  lpr_pkg::lpr_basic_s basic_cfg;
  lpr_pkg::lpr_adv_s adv_cfg;
  lpr_pkg::lpr_result_s result;
  lpr_pkg::lpr_qwr_s q_wr_data;
  int miscompares, checked;
  lpr_receiver dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_start(cmd_start), .cmd_advanced(cmd_advanced),
    .basic_cfg(basic_cfg), .adv_cfg(adv_cfg), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .end_trig_pin(end_trig_pin), .busy(busy), .synth_off(synth_off), .cmd_done(cmd_done), .result(result),
    .result_addr(result_addr), .q_wr(q_wr), .q_wr_data(q_wr_data));
  lpr_host_model host_u (.ref_clk(ref_clk), .q_wr(q_wr), .q_wr_data(q_wr_data));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // The done pulse may fall inside stimulus, so it is latched here.
  always @(posedge ref_clk) if (cmd_done === 1'b1) done_seen <= 1'b1;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One byte MSB first, with the bench CRC following along.
  task send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge ref_clk);
      rx_bit_valid = 1'b1;
      rx_bit = b[i];
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    end
  endtask
  task send_sync;
    for (int k = 3; k >= 0; k--) send_byte(basic_cfg.sync_pattern[8*k +: 8]);
    crc = 16'hFFFF;
  endtask
  // Packet bytes, optional CRC with chosen bits flipped, then an idle gap.
  task send_pk(input logic use_crc, input logic [15:0] flip);
    logic [15:0] c;
    foreach (pk[i]) send_byte(pk[i]);
    c = crc ^ flip;
    if (use_crc) begin
      send_byte(c[15:8]);
      send_byte(c[7:0]);
    end
    @(negedge ref_clk);
    rx_bit_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task start_cmd(input logic [7:0] opts, input logic [7:0] len, input logic [7:0] trig);
    @(negedge ref_clk);
    basic_cfg.packet_options = opts;
    basic_cfg.length_limit = len;
    basic_cfg.stop_trigger_class = trig;
    adv_cfg.packet_options = opts;
    adv_cfg.stop_trigger_class = trig;
    done_seen = 1'b0;
    cmd_start = 1'b1;
    @(negedge ref_clk);
    cmd_start = 1'b0;
    check(busy, 1'b1);
  endtask
  task wait_done(input logic [31:0] exp, input logic [31:0] mask);
    int n;
    n = 0;
    while (done_seen !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
      tally_and_finish;
    end else begin
      check(result & mask, exp);
    end
  endtask
  initial begin
    {cmd_start, cmd_advanced, rx_bit_valid, rx_bit, end_trig_pin, rst_n, done_seen} = '0;
    basic_cfg = '0;
    adv_cfg = '0;
    basic_cfg.sync_pattern = 32'hD391A5C3;
    basic_cfg.rx_queue_ptr = 32'h20000102;
    basic_cfg.result_ptr = 32'h20000200;
    basic_cfg.match_addr_a = 8'h55;
    basic_cfg.match_addr_b = 8'hFF;
    basic_cfg.stop_time = 32'h00000028;
    adv_cfg.stop_time = 32'h00000028;
    adv_cfg.primary_sync_pattern = 32'hD391A5C3;
    seed = 32'h0000618F;
    miscompares = 0;
    checked = 0;
    base = 32'h20000100;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    // Fixed four-byte packet, then the synthesizer is switched off.
    start_cmd(8'h01, 8'h04, 8'h00);
    send_sync;
    pk = {rnd(), rnd(), rnd(), rnd()};
    send_pk(1'b0, 16'h0000);
    wait_done(32'h01010000, 32'hFFFFFFFF);
    check(synth_off, 1'b1);
    foreach (pk[i]) check(host_u.ram[base + i], pk[i]);
    // Zero address via the all-ones match, resume, then a CRC error ends it.
    start_cmd(8'h3A, 8'h10, 8'h00);
    send_sync;
    pk = {8'h02, 8'h00, rnd()};
    send_pk(1'b1, 16'h0000);
    send_sync;
    pk[1] = 8'h55;
    send_pk(1'b1, 16'h0100);
    wait_done(32'h02010100, 32'hFFFFFFFF);
    check(synth_off, 1'b0);
    // Address mismatch kept and marked ignored.
    start_cmd(8'hB0, 8'h10, 8'h00);
    send_sync;
    pk = {8'h01, 8'h77};
    send_pk(1'b0, 16'h0000);
    wait_done(32'h00000001, 32'h00FFFFFF);
    // Length byte above the limit is a bad packet.
    start_cmd(8'h10, 8'h03, 8'h00);
    send_sync;
    pk = {8'h05, rnd(), rnd(), rnd(), rnd(), rnd()};
    send_pk(1'b0, 16'h0000);
    wait_done(32'h02000100, 32'hFFFFFFFF);
    // Mismatch restarts search; the stop time has passed by then.
    start_cmd(8'h30, 8'h10, 8'h01);
    send_sync;
    pk = {8'h01, 8'h77};
    send_pk(1'b0, 16'h0000);
    wait_done(32'h03000000, 32'hFFFFFFFF);
    // Stop pin edge while still searching.
    start_cmd(8'h00, 8'h00, 8'h02);
    repeat (5) @(negedge ref_clk);
    end_trig_pin = 1'b1;
    wait_done(32'h03000000, 32'hFFFFFFFF);
    end_trig_pin = 1'b0;
    // Advanced run cut short by the stop time.
    cmd_advanced = 1'b1;
    start_cmd(8'h40, 8'h00, 8'h01);
    send_sync;
    send_pk(1'b0, 16'h0000);
    wait_done(32'h04000000, 32'hFFFFFFFF);
    tally_and_finish;
  end
endmodule
